// *** design/timer_pair_capture_pingpong.sv ***
`timescale 1ns/1ps
// Behaviour
// - first selected edge captures then reloads
// - later edges capture complemented count, reload ones
// - edge capture sets edge status; every capture raises masked capture interrupt
// - single-edge set: later edges ignored
// - single-edge: narrow time-out captures without reload
// - writing single-edge 0 then 1 re-arms
// - demodulation: zero wraps to ones, time-out flagged
// - alternating starts by enable; narrow loads by level
// - narrow terminal hands over to wide counter
// - wide terminal hands back to narrow counter
// - each terminal may raise its time-out interrupt
// - mode field zero requests end of alternating
// - hardware clears enable bits on hand-over
// - time-out status set on every terminal count
// - alternating ends at next time-out only
// - time-out status cleared only by writing one
// - edge detector selects polarity, filters glitches
module timer_pair_capture_pingpong
  import timer_pair_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        edgeIn,
  output logic             narrowOut,
  output logic             wideOut,
  output logic             captureIrq,
  output logic             narrowTimeoutIrq,
  output logic             wideTimeoutIrq
);

  // ----------------------------------------------------------------
  // state and decoded helpers
  // ----------------------------------------------------------------
  state_t   s;          // registered state
  state_t   n;          // next state
  outMode_t omode;      // output mode field
  logic     demod;      // demodulation mode
  logic     pingpong;   // alternating mode in transmit
  logic     doWr;       // address and data both held
  logic     wrN;        // write to narrow control
  logic     wrW;        // write to wide control
  logic     startN;     // narrow counter starts
  logic     startW;     // wide counter starts
  logic     stopN;      // narrow counter stopped by software
  logic     stopW;      // wide counter stopped by software
  logic     ppToW;      // hand-over narrow to wide
  logic     ppToN;      // hand-over wide to narrow
  logic     nTerm;      // narrow terminal count
  logic     wTerm;      // wide terminal count
  logic     posE;       // filtered rising edge
  logic     negE;       // filtered falling edge
  logic     edgeHit;    // selected edge seen
  logic     capEdge;    // capture on an edge
  logic     capTo;      // capture on narrow time-out
  logic [3:0] fLimit;   // glitch filter width in cycles

  assign demod    = s.mCtl[DEMOD_BIT];
  assign omode    = outMode_t'(s.mCtl[OMODE_MSB:OMODE_LSB]);
  assign pingpong = !demod && (omode == OUT_PINGPONG);
  assign doWr     = !s.awRdy && !s.wRdy && !s.bValid;
  assign wrN      = doWr && (s.awAddr == OFF_NARROW_CTL) && s.wStrb[0];
  assign wrW      = doWr && (s.awAddr == OFF_WIDE_CTL) && s.wStrb[0];
  assign nTerm    = s.nRun && (s.nCnt == 8'h00);
  assign wTerm    = s.wRun && (s.wCnt == 16'h0000);
  assign ppToW    = pingpong && nTerm;
  assign ppToN    = pingpong && wTerm;
  // only a falling enable stops: a bit cleared by hand-over may be written back as 0
  assign stopN    = wrN && s.nCtl[EN_BIT] && !s.wData[EN_BIT];
  assign stopW    = wrW && s.wCtl[EN_BIT] && !s.wData[EN_BIT];
  assign startN   = (wrN && s.wData[EN_BIT] && !s.nRun) || ppToN;
  assign startW   = (wrW && s.wData[EN_BIT] && !s.wRun) || ppToW;
  assign posE     = s.filt && !s.filtPrev;
  assign negE     = !s.filt && s.filtPrev;
  assign edgeHit  = (posE && s.mCtl[EDGE_POS]) || (negE && s.mCtl[EDGE_NEG]);
  assign capEdge  = demod && s.wRun && !startW && !stopW && edgeHit
                    && (!s.started || !s.wCtl[SINGLE_BIT]);
  assign capTo    = demod && s.wRun && !startW && !stopW && !capEdge && nTerm
                    && s.wCtl[SINGLE_BIT] && s.started;
  assign fLimit   = demod ? (4'(s.mCtl[OMODE_MSB:OMODE_LSB]) << FILT_SHIFT) : 4'h0;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n        = s;
    n.capIrq = 1'b0;
    n.nToIrq = 1'b0;
    n.wToIrq = 1'b0;

    // write address and data channels, taken in either order
    if (s.awRdy && awvalid) begin
      n.awRdy  = 1'b0;
      n.awAddr = awaddr;
    end
    if (s.wRdy && wvalid) begin
      n.wRdy  = 1'b0;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    // response handshake frees both channels
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
      n.awRdy  = 1'b1;
      n.wRdy   = 1'b1;
    end

    // register write once both halves are held
    if (doWr) begin
      n.bValid = 1'b1;
      n.bResp  = RESP_OKAY;
      if (s.awAddr == OFF_NARROW_CTL) begin
        if (s.wStrb[0]) begin
          n.nCtl         = s.wData[7:0];
          n.nCtl[TO_BIT] = s.nCtl[TO_BIT] && !s.wData[TO_BIT];
        end
      end else if (s.awAddr == OFF_MODE_CTL) begin
        n.mCtl = laneMerge(s.mCtl, s.wData[7:0], s.wStrb[0]);
        // in demodulation the low bits also read as edge status, write 1 clears
        if (s.wStrb[0] && demod) begin
          n.edgePos = s.edgePos && !s.wData[N_INIT_BIT];
          n.edgeNeg = s.edgeNeg && !s.wData[W_INIT_BIT];
        end
      end else if (s.awAddr == OFF_WIDE_CTL) begin
        if (s.wStrb[0]) begin
          n.wCtl         = s.wData[7:0];
          n.wCtl[TO_BIT] = s.wCtl[TO_BIT] && !s.wData[TO_BIT];
          // single-edge written 0 then 1 re-arms the first-edge capture
          if (s.wData[SINGLE_BIT] && !s.wCtl[SINGLE_BIT]) n.started = 1'b0;
        end
      end else if (s.awAddr == OFF_NARROW_REL) begin
        n.nRel = {laneMerge(s.nRel[15:8], s.wData[15:8], s.wStrb[1]),
                  laneMerge(s.nRel[7:0], s.wData[7:0], s.wStrb[0])};
      end else if (s.awAddr == OFF_WIDE_REL) begin
        n.wRel = {laneMerge(s.wRel[15:8], s.wData[15:8], s.wStrb[1]),
                  laneMerge(s.wRel[7:0], s.wData[7:0], s.wStrb[0])};
      end else if ((s.awAddr == OFF_CAPTURE) || (s.awAddr == OFF_COUNT)) begin
        n.bResp = RESP_OKAY;  // read-only, write ignored
      end else begin
        n.bResp = RESP_SLVERR;  // unmapped
      end
    end

    // read channel, one outstanding read
    if (s.rValid && rready) begin
      n.rValid = 1'b0;
      n.arRdy  = 1'b1;
    end
    if (s.arRdy && arvalid) begin
      n.arRdy  = 1'b0;
      n.rValid = 1'b1;
      n.rResp  = RESP_OKAY;
      n.rData  = 32'h0000_0000;
      if (araddr == OFF_NARROW_CTL) begin
        n.rData[7:0] = s.nCtl;
      end else if (araddr == OFF_MODE_CTL) begin
        n.rData[7:0] = demod ? {s.mCtl[7:2], s.edgePos, s.edgeNeg} : s.mCtl;
      end else if (araddr == OFF_WIDE_CTL) begin
        n.rData[7:0] = s.wCtl;
      end else if (araddr == OFF_NARROW_REL) begin
        n.rData[15:0] = s.nRel;
      end else if (araddr == OFF_WIDE_REL) begin
        n.rData[15:0] = s.wRel;
      end else if (araddr == OFF_CAPTURE) begin
        n.rData[15:0] = s.cap;
      end else if (araddr == OFF_COUNT) begin
        n.rData[23:0] = {s.nCnt, s.wCnt};
      end else begin
        n.rResp = RESP_SLVERR;
      end
    end

    // glitch filter: input must differ for longer than the limit
    n.filtPrev = s.filt;
    if (edgeIn == s.filt) begin
      n.fCnt = 4'h0;
    end else if (s.fCnt >= fLimit) begin
      n.filt = edgeIn;
      n.fCnt = 4'h0;
    end else begin
      n.fCnt = s.fCnt + 4'h1;
    end

    // narrow counter
    if (startN) begin
      n.nRun = 1'b1;
      n.nOut = s.mCtl[N_INIT_BIT];
      n.nCnt = s.mCtl[N_INIT_BIT] ? s.nRel[15:8] : s.nRel[7:0];
    end else if (stopN) begin
      n.nRun = 1'b0;
    end else if (nTerm) begin
      n.nCtl[TO_BIT] = 1'b1;
      n.nToIrq       = s.nCtl[TOIE_BIT];
      if (demod) begin
        n.nCnt = NARROW_ONES;
      end else begin
        n.nOut = !s.nOut;
        if (s.nCtl[SINGLE_BIT] || pingpong) begin
          n.nRun = 1'b0;
          if (pingpong) n.nCtl[EN_BIT] = 1'b0;
        end else begin
          n.nCnt = s.nOut ? s.nRel[7:0] : s.nRel[15:8];
        end
      end
    end else if (s.nRun) begin
      n.nCnt = s.nCnt - 8'h01;
    end else begin
      n.nOut = !s.mCtl[N_INIT_BIT];  // idle level
    end

    // wide counter
    if (startW) begin
      n.wRun = 1'b1;
      n.wOut = s.mCtl[W_INIT_BIT];
      n.wCnt = s.wRel;
      if (ppToW) n.wCtl[EN_BIT] = 1'b0;
      if (demod) n.started = 1'b0;
    end else if (stopW) begin
      n.wRun = 1'b0;
    end else if (s.wRun && demod) begin
      n.wCnt = s.wCnt - 16'h0001;  // zero wraps to all ones
      if (wTerm) begin
        n.wCtl[TO_BIT] = 1'b1;
        n.wToIrq       = s.wCtl[TOIE_BIT];
      end
      if (capEdge) begin
        n.cap     = ~s.wCnt;
        n.wCnt    = WIDE_ONES;
        n.started = 1'b1;
        n.edgePos = s.edgePos || posE;
        n.edgeNeg = s.edgeNeg || negE;
        n.capIrq  = s.wCtl[CAPM_BIT];
      end else if (capTo) begin
        n.cap    = ~s.wCnt;
        n.capIrq = s.wCtl[CAPM_BIT];
      end
    end else if (wTerm) begin
      n.wCtl[TO_BIT] = 1'b1;
      n.wToIrq       = s.wCtl[TOIE_BIT];
      n.wOut         = !s.wOut;
      if (s.wCtl[SINGLE_BIT] || pingpong) begin
        n.wRun = 1'b0;
        if (pingpong) n.wCtl[EN_BIT] = 1'b0;
      end else begin
        n.wCnt = s.wRel;
      end
    end else if (s.wRun) begin
      n.wCnt = s.wCnt - 16'h0001;
    end else begin
      n.wOut = !s.mCtl[W_INIT_BIT];
    end
    // forced wide output level in transmit mode, running or not
    if (!demod && ((omode == OUT_FORCE0) || (omode == OUT_FORCE1))) begin
      n.wOut = (omode == OUT_FORCE1);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign awready          = s.awRdy;
  assign wready           = s.wRdy;
  assign bvalid           = s.bValid;
  assign bresp            = s.bResp;
  assign arready          = s.arRdy;
  assign rvalid           = s.rValid;
  assign rresp            = s.rResp;
  assign rdata            = s.rData;
  assign narrowOut        = s.nOut;
  assign wideOut          = s.wOut;
  assign captureIrq       = s.capIrq;
  assign narrowTimeoutIrq = s.nToIrq;
  assign wideTimeoutIrq   = s.wToIrq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_EDGE_CAPTURE: assert property ((capEdge && !wTerm) |=>
                                     (s.cap == ~$past(s.wCnt)) && (s.wCnt == WIDE_ONES))
    else $error("edge capture wrong value or no reload");
  AST_IGNORE_EDGE: assert property ((demod && s.wRun && edgeHit && s.started && s.wCtl[SINGLE_BIT] && !nTerm
                                     && !startW && !stopW) |=> $stable(s.cap))
    else $error("ignored edge changed capture");
  AST_TO_CAPTURE: assert property (capTo && (s.wCnt != 16'h0000) |=>
                                   (s.cap == ~$past(s.wCnt)) && (s.wCnt == $past(s.wCnt) - 16'h0001))
    else $error("narrow time-out capture reloaded or wrong");
  AST_CAP_IRQ: assert property ((capEdge || capTo) |=> (captureIrq == $past(s.wCtl[CAPM_BIT])))
    else $error("capture interrupt not gated by mask");
  AST_WRAP: assert property ((demod && wTerm && !startW && !stopW) |=>
                             (s.wCnt == WIDE_ONES) && s.wCtl[TO_BIT])
    else $error("wide counter did not wrap with status");
  AST_HANDOVER_W: assert property (ppToW |=>
                                   s.wRun && !s.nRun && !s.nCtl[EN_BIT] && (s.wCnt == $past(s.wRel)))
    else $error("narrow terminal did not hand over");
  AST_HANDOVER_N: assert property ((ppToN && !wrN) |=> s.nRun && !s.wRun ##1 s.nRun)
    else $error("wide terminal did not hand back");
  AST_STATUS_HOLD: assert property ((s.wCtl[TO_BIT] && !(wrW && s.wData[TO_BIT])) |=> s.wCtl[TO_BIT])
    else $error("time-out status lost without write one");
  AST_FILTER: assert property ((s.filt != $past(s.filt)) |-> ($past(edgeIn) == s.filt))
    else $error("filtered level changed without input");
  AST_BOTH_EVENTS: assert property ((capEdge && wTerm) |=> s.wCtl[TO_BIT] && (s.cap == WIDE_ONES))
    else $error("simultaneous capture and terminal lost one");

endmodule

// *** design/timer_pair_pkg.sv ***
package timer_pair_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_NARROW_CTL = 8'h00;  // narrow_counter_control
  localparam logic [7:0] OFF_MODE_CTL   = 8'h04;  // counter_mode_control
  localparam logic [7:0] OFF_WIDE_CTL   = 8'h08;  // wide_counter_control
  localparam logic [7:0] OFF_NARROW_REL = 8'h0c;  // narrow_reload_high/low
  localparam logic [7:0] OFF_WIDE_REL   = 8'h10;  // wide_reload_high/low
  localparam logic [7:0] OFF_CAPTURE    = 8'h14;  // wide_capture_high/low
  localparam logic [7:0] OFF_COUNT      = 8'h18;  // live counts

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EN_BIT     = 7;  // counter enable
  localparam int SINGLE_BIT = 6;  // single-pass / single-edge
  localparam int TO_BIT     = 5;  // time-out status, write 1 clears
  localparam int CAPM_BIT   = 2;  // capture interrupt mask
  localparam int TOIE_BIT   = 1;  // time-out interrupt enable
  localparam int DEMOD_BIT  = 7;  // mode control: 1 = demodulation
  localparam int EDGE_NEG   = 5;  // edge select: falling edges
  localparam int EDGE_POS   = 4;  // edge select: rising edges
  localparam int OMODE_MSB  = 3;  // output mode / glitch filter field
  localparam int OMODE_LSB  = 2;
  localparam int N_INIT_BIT = 1;  // narrow initial level / rising status
  localparam int W_INIT_BIT = 0;  // wide initial level / falling status

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [7:0]  NARROW_ONES = 8'hff;
  localparam logic [15:0] WIDE_ONES   = 16'hffff;
  localparam logic [7:0]  CTL_RST     = 8'h00;
  localparam logic [15:0] REL_RST     = 16'h0000;
  localparam logic [1:0]  FILT_SHIFT  = 2'h2;  // filter cycles = field * 4

  // byte-lane merge, used for the mode and reload registers
  function automatic logic [7:0] laneMerge(input logic [7:0] old, input logic [7:0] nw, input logic en);
    laneMerge = en ? nw : old;
  endfunction

  typedef enum logic [1:0] {
    OUT_NORMAL   = 2'b00,
    OUT_PINGPONG = 2'b01,
    OUT_FORCE0   = 2'b10,
    OUT_FORCE1   = 2'b11
  } outMode_t;

  // ----------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awRdy;
    logic        wRdy;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rValid;
    logic [1:0]  rResp;
    logic [31:0] rData;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [7:0]  nCtl;
    logic [7:0]  mCtl;
    logic [7:0]  wCtl;
    logic [15:0] nRel;
    logic [15:0] wRel;
    logic [15:0] cap;
    logic        edgePos;
    logic        edgeNeg;
    logic [7:0]  nCnt;
    logic [15:0] wCnt;
    logic        nRun;
    logic        wRun;
    logic        started;
    logic        nOut;
    logic        wOut;
    logic        filt;
    logic        filtPrev;
    logic [3:0]  fCnt;
    logic        capIrq;
    logic        wToIrq;
    logic        nToIrq;
  } state_t;

  // filter starts at the receiver's idle high level, so no false edge follows reset
  localparam state_t ST_RST = '{awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, nOut: 1'b1, wOut: 1'b1,
                                nCtl: CTL_RST, mCtl: CTL_RST, wCtl: CTL_RST, filt: 1'b1, filtPrev: 1'b1,
                                nRel: REL_RST, wRel: REL_RST, default: '0};

endpackage

// *** tb/ir_receiver_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// receiver output model: a clean level, idle high
// ----------------------------------------------------------------
module ir_receiver_model (
  output logic edgeIn,
  input  wire logic clk
);
  initial edgeIn = 1'b1;  // idle level of the receiver

  // new level right after an edge, then held for some edges
  task automatic setLevel(input logic v, input int hold);
    @(posedge clk);
    edgeIn <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// *** tb/tb_timer_pair_capture_pingpong.sv ***
`timescale 1ns/1ps
module tb_timer_pair_capture_pingpong;
  import timer_pair_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr = '0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = '0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, edgeIn;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        narrowOut, wideOut, captureIrq, narrowTimeoutIrq, wideTimeoutIrq;
  int          fails = 0;
  int          checks = 0;
  int          capCnt = 0;  // capture pulses seen
  int          nToCnt = 0;  // narrow time-out pulses seen
  int          wToCnt = 0;  // wide time-out pulses seen

  always #5 clk = ~clk;

  ir_receiver_model ir (.edgeIn(edgeIn), .clk(clk));

  timer_pair_capture_pingpong dut (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .edgeIn(edgeIn), .narrowOut(narrowOut), .wideOut(wideOut), .captureIrq(captureIrq),
    .narrowTimeoutIrq(narrowTimeoutIrq), .wideTimeoutIrq(wideTimeoutIrq)
  );

  // one-cycle pulses counted at the edge that sees them
  always @(posedge clk) begin
    if (captureIrq === 1'b1) capCnt++;
    if (narrowTimeoutIrq === 1'b1) nToCnt++;
    if (wideTimeoutIrq === 1'b1) wToCnt++;
  end

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // bounded wait guard
  task automatic hang(input int n);
    if (n > 100) begin
      fails++;
      $display("BAD %0t wait too long", $time);
      report_and_stop();
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      hang(n);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp === er, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      hang(n);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk(rresp === er, "read response");
  endtask

  // poll a control register until its time-out flag sets
  task automatic pollTo(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    do begin
      rd(a, RESP_OKAY, d);
      n++;
      hang(n);
    end while (d[TO_BIT] !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] d;
    chk(narrowOut === 1'b1 && wideOut === 1'b1, "idle outputs");
    rd(OFF_MODE_CTL, RESP_OKAY, d);
    chk(d === 32'h0, "mode reset value");
    rd(OFF_WIDE_CTL, RESP_OKAY, d);
    chk(d === 32'h0, "wide reset value");
    rd(8'h1c, RESP_SLVERR, d);
    chk(d === 32'h0, "unmapped read");
    wr(8'h1c, 32'h1, RESP_SLVERR);
    wr(OFF_CAPTURE, 32'h1234, RESP_OKAY);
    rd(OFF_CAPTURE, RESP_OKAY, d);
    chk(d === 32'h0, "capture read-only");
  endtask

  task automatic s_demod();
    logic [31:0] d;
    int          c0;
    wr(OFF_WIDE_REL, 32'hffff, RESP_OKAY);
    wr(OFF_MODE_CTL, 32'h90, RESP_OKAY);
    ir.setLevel(1'b0, 10);
    wr(OFF_WIDE_CTL, 32'h84, RESP_OKAY);
    c0 = capCnt;
    ir.setLevel(1'b1, 20);
    chk(capCnt == c0 + 1, "first edge capture");
    ir.setLevel(1'b0, 30);
    chk(capCnt == c0 + 1, "falling edge ignored");
    ir.setLevel(1'b1, 10);
    chk(capCnt == c0 + 2, "second edge capture");
    rd(OFF_CAPTURE, RESP_OKAY, d);
    chk(d >= 32'd50 && d <= 32'd54, "captured width");
    rd(OFF_MODE_CTL, RESP_OKAY, d);
    chk(d[N_INIT_BIT] === 1'b1, "rising status");
    wr(OFF_MODE_CTL, 32'h92, RESP_OKAY);
    rd(OFF_MODE_CTL, RESP_OKAY, d);
    chk(d[N_INIT_BIT] === 1'b0, "status cleared");
    wr(OFF_WIDE_CTL, 32'h80, RESP_OKAY);
    ir.setLevel(1'b0, 5);
    ir.setLevel(1'b1, 10);
    chk(capCnt == c0 + 2, "masked capture");
    rd(OFF_MODE_CTL, RESP_OKAY, d);
    chk(d[N_INIT_BIT] === 1'b1, "status without irq");
  endtask

  task automatic s_single();
    int c0;
    wr(OFF_WIDE_CTL, 32'hc4, RESP_OKAY);
    c0 = capCnt;
    ir.setLevel(1'b0, 5);
    ir.setLevel(1'b1, 10);
    chk(capCnt == c0 + 1, "armed edge");
    ir.setLevel(1'b0, 5);
    ir.setLevel(1'b1, 10);
    chk(capCnt == c0 + 1, "later edge ignored");
    wr(OFF_WIDE_CTL, 32'h84, RESP_OKAY);
    wr(OFF_WIDE_CTL, 32'hc4, RESP_OKAY);
    ir.setLevel(1'b0, 5);
    ir.setLevel(1'b1, 10);
    chk(capCnt == c0 + 2, "re-armed edge");
    wr(OFF_NARROW_REL, 32'h1010, RESP_OKAY);
    wr(OFF_NARROW_CTL, 32'h80, RESP_OKAY);
    ir.setLevel(1'b0, 300);
    chk(capCnt >= c0 + 3, "narrow time-out capture");
    wr(OFF_NARROW_CTL, 32'h00, RESP_OKAY);
  endtask

  task automatic s_wrap();
    logic [31:0] d;
    int          w0;
    wr(OFF_WIDE_CTL, 32'h00, RESP_OKAY);
    wr(OFF_WIDE_CTL, 32'h20, RESP_OKAY);
    wr(OFF_WIDE_REL, 32'h0020, RESP_OKAY);
    w0 = wToCnt;
    wr(OFF_WIDE_CTL, 32'h82, RESP_OKAY);
    // rising edge timed to land in the terminal-count cycle
    repeat (29) @(posedge clk);
    ir.setLevel(1'b1, 30);
    chk(wToCnt == w0 + 1, "wide wrap irq");
    rd(OFF_COUNT, RESP_OKAY, d);
    chk(d[15:8] === 8'hff, "wrapped to ones");
    rd(OFF_CAPTURE, RESP_OKAY, d);
    chk(d === 32'h0000ffff, "capture at terminal");
    wr(OFF_WIDE_CTL, 32'h82, RESP_OKAY);
    rd(OFF_WIDE_CTL, RESP_OKAY, d);
    chk(d[TO_BIT] === 1'b1, "zero write keeps flag");
    wr(OFF_WIDE_CTL, 32'ha2, RESP_OKAY);
    rd(OFF_WIDE_CTL, RESP_OKAY, d);
    chk(d[TO_BIT] === 1'b0, "one write clears flag");
    wr(OFF_WIDE_CTL, 32'h00, RESP_OKAY);
  endtask

  task automatic s_filter();
    logic [31:0] d;
    int          c0;
    wr(OFF_MODE_CTL, 32'ha4, RESP_OKAY);
    ir.setLevel(1'b1, 20);
    wr(OFF_WIDE_CTL, 32'h84, RESP_OKAY);
    c0 = capCnt;
    ir.setLevel(1'b0, 1);
    ir.setLevel(1'b1, 20);
    chk(capCnt == c0, "glitch filtered");
    ir.setLevel(1'b0, 20);
    chk(capCnt == c0 + 1, "falling capture");
    rd(OFF_MODE_CTL, RESP_OKAY, d);
    chk(d[W_INIT_BIT] === 1'b1, "falling status");
    wr(OFF_WIDE_CTL, 32'h00, RESP_OKAY);
  endtask

  task automatic s_pingpong();
    logic [31:0] d;
    int          n0, w0;
    wr(OFF_NARROW_CTL, 32'h20, RESP_OKAY);
    wr(OFF_WIDE_CTL, 32'h20, RESP_OKAY);
    wr(OFF_NARROW_REL, 32'h0c08, RESP_OKAY);
    wr(OFF_WIDE_REL, 32'h0010, RESP_OKAY);
    wr(OFF_MODE_CTL, 32'h04, RESP_OKAY);
    wr(OFF_NARROW_CTL, 32'h42, RESP_OKAY);
    wr(OFF_WIDE_CTL, 32'h42, RESP_OKAY);
    n0 = nToCnt;
    w0 = wToCnt;
    wr(OFF_NARROW_CTL, 32'hc2, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(narrowOut === 1'b0, "narrow initial level");
    repeat (200) @(posedge clk);
    chk(nToCnt - n0 >= 3 && wToCnt - w0 >= 3, "phases repeat");
    rd(OFF_NARROW_CTL, RESP_OKAY, d);
    wr(OFF_NARROW_CTL, d | 32'h20, RESP_OKAY);
    pollTo(OFF_NARROW_CTL, d);
    chk(d[EN_BIT] === 1'b0, "narrow enable cleared");
    wr(OFF_MODE_CTL, 32'h00, RESP_OKAY);
    rd(OFF_WIDE_CTL, RESP_OKAY, d);
    wr(OFF_WIDE_CTL, d | 32'h20, RESP_OKAY);
    pollTo(OFF_WIDE_CTL, d);
    n0 = nToCnt;
    w0 = wToCnt;
    repeat (100) @(posedge clk);
    chk(nToCnt == n0 && wToCnt == w0, "alternation ended");
    // forced wide output levels in transmit mode
    wr(OFF_MODE_CTL, 32'h08, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(wideOut === 1'b0, "wide forced low");
    wr(OFF_MODE_CTL, 32'h0c, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(wideOut === 1'b1, "wide forced high");
    wr(OFF_MODE_CTL, 32'h00, RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    s_reset();
    s_demod();
    s_single();
    s_wrap();
    s_filter();
    s_pingpong();
    report_and_stop();
  end
endmodule
